// ==== verilog/reader_defs.svh ====
// Functional notes
// - Line A, and line B when the secondary channel is enabled, are captured in the same serial clock cycles, one shift channel each.
// - The frame output is active low; driving it low selects the converter.
// - A frame holds 16 bits by default or 14 bits when so configured.
// - The frame stays asserted across the whole word and one frame is issued per word.
// - Each result bit is sampled at the falling edge of the serial clock.
// - The falling busy line reports conversion complete and starts the read.
// - The transmit frame output is the converter chip select; one frame is one access.
// - The receive channels are framed by the same transmit frame signal.
// - On conversion complete a control word is sent, and its frame starts the read.
// - When the secondary channel is enabled, line B is read in parallel on the same port.
`ifndef READER_DEFS_SVH
`define READER_DEFS_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_HALF 8'h04
`define REG_TXWORD 8'h08
`define REG_STATUS 8'h0c
`define REG_DATA 8'h10

// Control register fields
`define CTRL_EN 0
`define CTRL_WORD14 1
`define CTRL_SECEN 2
`define CTRL_RES14 3

// Status register fields
`define STAT_BUSY 0
`define STAT_PEND 1
`define STAT_ACTIVE 2
`define STAT_EMPTY 3
`define STAT_FULL 4

// Reset values
`define CTRL_RST 4'h5
`define TXWORD_RST 16'h0000

// Word and result lengths
`define WORD_LONG 5'h10
`define WORD_SHORT 5'h0e
`define RES_LONG 5'h0e
`define RES_SHORT 5'h0c

// Serial clock timing
`define SYS_PERIOD_NS 10
`define LINK_HALF_NS 60
`define HALF_CYC_DEF ((`LINK_HALF_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define HALF_CYC_MIN 8'h03

`define FIFO_DEPTH 16

`endif

// ==== verilog/reader_pkg.sv ====
package reader_pkg;

  typedef enum logic [1:0] {
    X_IDLE = 2'b00,
    X_HIGH = 2'b01,
    X_LOW = 2'b10,
    X_TAIL = 2'b11
  } xfer_e;

  typedef logic [7:0] apb_addr_t;

  typedef struct packed {
    xfer_e st;
    logic [7:0] div;
    logic [4:0] bitCnt;
    logic [15:0] shA;
    logic [15:0] shB;
    logic [15:0] tx;
    logic frameN;
    logic sclk;
    logic txd;
    logic pend;
    logic busyQ;
    logic en;
    logic word14;
    logic secEn;
    logic res14;
    logic [7:0] half;
    logic [15:0] ctrlWord;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic popOk;
  } reader_s;

endpackage

// ==== verilog/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [W-1:0] pinIn, // Asynchronous pins
  output logic [W-1:0] pinOut // Synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s q;
  sync_s n;

  // First stage feeds only the second stage
  always_comb begin
    n.s1 = pinIn;
    n.s2 = q.s1;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pinOut = q.s2;
endmodule
`default_nettype wire

// ==== verilog/word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  input wire logic [W-1:0] inData, // Write data
  output logic outValid, // Data available
  input wire logic outReady, // Read acknowledge
  output logic [W-1:0] outData // Head word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s q;
  fifo_s n;
  logic doWr;
  logic doRd;

  // Pointers wrap at DEPTH so any depth works, not only powers of two
  always_comb begin
    n = q;
    doWr = inValid && (q.cnt != FULL);
    doRd = outReady && (q.cnt != '0);
    if (doWr) begin
      n.mem[q.wr] = inData;
      n.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (doRd) begin
      n.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(doWr) - (AW+1)'(doRd);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign inReady = (q.cnt != FULL);
  assign outValid = (q.cnt != '0);
  assign outData = q.mem[q.rd];
endmodule
`default_nettype wire

// ==== verilog/host_serial_reader.sv ====
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reader_defs.svh"
module host_serial_reader #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire reader_pkg::apb_addr_t paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic busyIn, // Converter busy line
  input wire logic resultLineA, // Converter result line A
  input wire logic resultLineB, // Converter result line B
  output logic transmitFrameSyncN, // Frame, also chip select
  output logic serialClk, // Generated serial clock
  output logic txData // Control word out
);
  import reader_pkg::*;

  // Control bits come out of reset from the one reset word
  localparam logic [3:0] CTRL_INIT = `CTRL_RST;

  reader_s q;
  reader_s n;
  logic [2:0] pinS;
  logic busyS;
  logic lineA;
  logic lineB;
  logic [7:0] halfEff;
  logic lastTick;
  logic [4:0] wordBits;
  logic [4:0] resBits;
  logic [4:0] trimShift;
  logic [15:0] resA;
  logic [15:0] resB;
  logic [31:0] pushData;
  logic pushValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [31:0] fifoOutData;
  logic popReq;
  logic setupRd;
  logic accWr;

  // Pins from the converter cross into sys_clk before use
  pin_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinIn({busyIn, resultLineB, resultLineA}),
    .pinOut(pinS)
  );
  assign busyS = pinS[2];
  assign lineB = pinS[1];
  assign lineA = pinS[0];

  // Clamp the half period: sync latency must stay below one half period
  assign halfEff = (q.half < `HALF_CYC_MIN) ? `HALF_CYC_MIN : q.half;
  assign lastTick = (q.div == halfEff - 8'h01);

  // Word length and trimming of filler bits
  assign wordBits = q.word14 ? `WORD_SHORT : `WORD_LONG;
  assign resBits = q.res14 ? `RES_LONG : `RES_SHORT;
  assign trimShift = (wordBits > resBits) ? wordBits - resBits : 5'h00;
  assign resA = q.shA >> trimShift;
  assign resB = q.shB >> trimShift;
  assign pushData = {resB, resA};
  assign pushValid = (q.st == X_TAIL) && lastTick;

  word_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(fifoOutValid),
    .outReady(popReq),
    .outData(fifoOutData)
  );

  // APB phase decode
  assign setupRd = psel && !penable;
  assign accWr = psel && penable && q.rdy && pwrite;
  assign popReq = psel && penable && q.rdy && q.popOk;

  // Next state: frame sequencer, then register file, then busy edge
  always_comb begin
    n = q;
    n.busyQ = busyS;
    unique case (q.st)
      X_IDLE: begin
        // A frame starts only with room in the FIFO, so the push never drops
        if (q.pend && q.en && fifoInReady) begin
          n.pend = 1'b0;
          n.frameN = 1'b0;
          n.tx = q.ctrlWord;
          n.txd = q.ctrlWord[15];
          n.bitCnt = 5'h00;
          n.div = 8'h00;
          n.shA = 16'h0000;
          n.shB = 16'h0000;
          n.st = X_HIGH;
        end
      end
      X_HIGH: begin
        if (lastTick) begin
          n.div = 8'h00;
          n.sclk = 1'b0;
          // Sample line A, and line B when secEn is set, at the falling edge; device output is MSB first
          n.shA = {q.shA[14:0], lineA};
          n.shB = q.secEn ? {q.shB[14:0], lineB} : 16'h0000;
          n.bitCnt = q.bitCnt + 5'h01;
          n.tx = {q.tx[14:0], 1'b0};
          n.txd = q.tx[14];
          n.st = X_LOW;
        end else begin
          n.div = q.div + 8'h01;
        end
      end
      X_LOW: begin
        if (lastTick) begin
          n.div = 8'h00;
          n.sclk = 1'b1;
          n.st = (q.bitCnt == wordBits) ? X_TAIL : X_HIGH;
        end else begin
          n.div = q.div + 8'h01;
        end
      end
      X_TAIL: begin
        // Raising the frame floats the result lines at the converter
        if (lastTick) begin
          n.div = 8'h00;
          n.frameN = 1'b1;
          n.txd = 1'b0;
          n.st = X_IDLE;
        end else begin
          n.div = q.div + 8'h01;
        end
      end
    endcase

    // Register reads are captured in the setup cycle, so pready needs no wait
    n.rdy = setupRd;
    n.err = 1'b0;
    // Pop only after a setup that saw a word, so a push between the phases is kept
    n.popOk = setupRd && !pwrite && (paddr == `REG_DATA) && fifoOutValid;
    if (setupRd) begin
      n.rdata = 32'h00000000;
      unique case (paddr)
        `REG_CTRL: begin
          n.rdata[`CTRL_EN] = q.en;
          n.rdata[`CTRL_WORD14] = q.word14;
          n.rdata[`CTRL_SECEN] = q.secEn;
          n.rdata[`CTRL_RES14] = q.res14;
        end
        `REG_HALF: n.rdata[7:0] = q.half;
        `REG_TXWORD: n.rdata[15:0] = q.ctrlWord;
        `REG_STATUS: begin
          n.rdata[`STAT_BUSY] = busyS;
          n.rdata[`STAT_PEND] = q.pend;
          n.rdata[`STAT_ACTIVE] = (q.st != X_IDLE);
          n.rdata[`STAT_EMPTY] = !fifoOutValid;
          n.rdata[`STAT_FULL] = !fifoInReady;
        end
        `REG_DATA: n.rdata = fifoOutValid ? fifoOutData : 32'h00000000;
        default: n.err = 1'b1;
      endcase
    end
    if (accWr) begin
      unique case (paddr)
        `REG_CTRL: begin
          n.en = pwdata[`CTRL_EN];
          n.word14 = pwdata[`CTRL_WORD14];
          n.secEn = pwdata[`CTRL_SECEN];
          n.res14 = pwdata[`CTRL_RES14];
        end
        `REG_HALF: n.half = pwdata[7:0];
        `REG_TXWORD: n.ctrlWord = pwdata[15:0];
        default: ;
      endcase
    end

    // Busy falling edge marks a finished conversion; the set wins over the clear
    if (q.busyQ && !busyS) begin
      n.pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.frameN <= 1'b1;
      q.sclk <= 1'b1;
      q.en <= CTRL_INIT[`CTRL_EN];
      q.word14 <= CTRL_INIT[`CTRL_WORD14];
      q.secEn <= CTRL_INIT[`CTRL_SECEN];
      q.res14 <= CTRL_INIT[`CTRL_RES14];
      q.half <= 8'(`HALF_CYC_DEF);
      q.ctrlWord <= `TXWORD_RST;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign transmitFrameSyncN = q.frameN;
  assign serialClk = q.sclk;
  assign txData = q.txd;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence frameStart;
    $fell(transmitFrameSyncN);
  endsequence

  sequence frameEnd;
    $rose(transmitFrameSyncN);
  endsequence

  start_on_busy_a: assert property (
    frameStart |-> $past(q.pend))
    else $error("frame started without a finished conversion");

  tx_msb_a: assert property (
    frameStart |-> txData == $past(q.ctrlWord[15]))
    else $error("control word MSB not on line at frame start");

  frame_held_a: assert property (
    frameStart |-> ##1 !transmitFrameSyncN [*3])
    else $error("frame did not stay low");

  word_len_a: assert property (
    frameEnd |-> q.bitCnt == $past(wordBits))
    else $error("frame bit count wrong");

  clock_idle_a: assert property (
    transmitFrameSyncN |-> serialClk)
    else $error("serial clock toggled outside a frame");

  one_push_a: assert property (
    frameEnd |-> $past(pushValid))
    else $error("frame ended without a pushed word");

  sample_fall_a: assert property (
    $fell(serialClk) |-> q.bitCnt == $past(q.bitCnt) + 5'h01)
    else $error("bit not sampled at falling edge");

  sec_off_a: assert property (
    pushValid && !q.secEn |-> pushData[31:16] == 16'h0000)
    else $error("line B data with secondary disabled");

  trim_a: assert property (
    pushValid && !q.res14 |-> pushData[15:12] == 4'h0)
    else $error("filler bits kept in result");

  // Bus side: a setup cycle is answered at once, for one cycle only
  sequence apbSetup;
    psel && !penable;
  endsequence

  apb_ready_a: assert property (
    apbSetup |=> pready)
    else $error("pready missing after setup");

  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready held beyond one cycle");

  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");

  // Link side: pins idle, no word lost, half period never below the floor
  idle_pins_a: assert property (
    q.st == X_IDLE |-> transmitFrameSyncN && serialClk)
    else $error("frame or clock active while idle");

  tx_idle_a: assert property (
    transmitFrameSyncN |-> !txData)
    else $error("control word line busy outside a frame");

  frame_sclk_a: assert property (
    frameStart |-> serialClk)
    else $error("serial clock low at frame start");

  low_half_a: assert property (
    $fell(serialClk) |-> !serialClk [*3])
    else $error("serial clock low phase too short");

  push_room_a: assert property (
    pushValid |-> fifoInReady)
    else $error("word pushed into a full buffer");

  pend_set_a: assert property (
    q.busyQ && !busyS |=> q.pend)
    else $error("finished conversion not remembered");
endmodule
`default_nettype wire

// ==== tb/adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input wire logic sys_clk, // Bench clock, times the conversion
  input wire logic start, // Conversion request pulse
  input wire logic res14, // Wider result variant
  input wire logic [13:0] valA, // Result on line A
  input wire logic [13:0] valB, // Result on line B
  input wire logic csN, // Chip select, active low
  input wire logic sclk, // Serial clock from the host
  output logic busy, // High while converting
  output logic lineA, // Result line A
  output logic lineB // Result line B
);
  logic [13:0] shA, shB;
  int cnt = 0;
  initial begin
    busy = 0;
    lineA = 0;
    lineB = 0;
  end
  // Busy rises on a request and falls once the conversion is done
  always @(posedge sys_clk) begin
    if (start) begin
      busy <= 1;
      cnt <= 50;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) busy <= 0;
    end
  end
  // Select puts out the MSB, results left justified
  always @(negedge csN) begin
    shA = res14 ? valA : {valA[11:0], 2'b00};
    shB = res14 ? valB : {valB[11:0], 2'b00};
    lineA <= shA[13];
    lineB <= shB[13];
  end
  // Each falling clock moves on a bit; filler toggles so it is never kind
  always @(negedge sclk) begin
    if (!csN) begin
      shA = {shA[12:0], ~shA[13]};
      shB = {shB[12:0], ~shB[13]};
      lineA <= shA[13];
      lineB <= shB[13];
    end
  end
  // Released lines have no pull, so show the inverse of the last bit
  always @(posedge csN) begin
    lineA <= ~lineA;
    lineB <= ~lineB;
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "reader_defs.svh"
module tb_top;
  import reader_pkg::*;
  localparam int DEPTH = `FIFO_DEPTH;
  logic sys_clk = 0;
  logic nrst = 0;
  apb_addr_t paddr = '0;
  logic psel = 0, penable = 0, pwrite = 0, start = 0, res14 = 0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, busyIn, resultLineA, resultLineB, er;
  logic transmitFrameSyncN, serialClk, txData, sPrev, tPrev;
  logic [13:0] valA = 14'h2b6d, valB = 14'h1c93;
  logic [15:0] txCap, lastTx;
  int fLen = 0, nFall = 0, lastLen, lastFall, errTotal = 0, nChecks = 0;
  always #5 sys_clk = ~sys_clk;
  host_serial_reader #(.DEPTH(DEPTH)) u_dut (.sys_clk, .nrst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .busyIn, .resultLineA, .resultLineB,
    .transmitFrameSyncN, .serialClk, .txData);
  adc_model u_adc (.sys_clk, .start, .res14, .valA, .valB, .csN(transmitFrameSyncN),
    .sclk(serialClk), .busy(busyIn), .lineA(resultLineA), .lineB(resultLineB));
  // Wire monitor: frame length, clock falls and the control word bits
  always @(posedge sys_clk) begin
    sPrev <= serialClk;
    tPrev <= txData;
    if (transmitFrameSyncN === 1'b0) begin
      fLen <= fLen + 1;
      if (sPrev && !serialClk) begin
        nFall <= nFall + 1;
        txCap <= {txCap[14:0], tPrev};
      end
    end else if (fLen != 0) begin
      lastLen <= fLen;
      lastFall <= nFall;
      lastTx <= txCap;
      fLen <= 0;
      nFall <= 0;
    end
  end
  task automatic giveVerdict;
    if (errTotal == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for pready, then idles one cycle
  task automatic apb(input logic w, input apb_addr_t a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
    chk("wait states", 0, n);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input apb_addr_t a, input logic [31:0] d);
    apb(1, a, d, rd, er);
  endtask
  task automatic rdc(input apb_addr_t a, input logic [31:0] e, input string nm);
    apb(0, a, 0, rd, er);
    chk(nm, e, rd);
  endtask
  // Waits for one whole frame, or for none when the read is held back
  task automatic waitFrame(input bit expF);
    bit seen;
    seen = 0;
    for (int n = 0; n < 700; n++) begin
      @(posedge sys_clk);
      if (busyIn === 1'b1 && transmitFrameSyncN === 1'b0) chk("frame in busy", 1, 0);
      if (transmitFrameSyncN === 1'b0) seen = 1;
      else if (seen) break;
    end
    @(posedge sys_clk);
    chk("frame seen", expF, seen);
  endtask
  task automatic conv(input bit expF);
    start <= 1;
    @(posedge sys_clk);
    start <= 0;
    waitFrame(expF);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    chk("frame idle", 1, transmitFrameSyncN);
    rdc(`REG_CTRL, `CTRL_RST, "ctrl");
    rdc(`REG_HALF, 6, "half");
    rdc(`REG_TXWORD, `TXWORD_RST, "txword");
    rdc(`REG_STATUS, 32'h8, "status");
    apb(0, 8'h14, 0, rd, er);
    chk("slverr", 1, er);
    wr(`REG_TXWORD, 32'ha5c3);
    wr(`REG_HALF, 3);
    conv(1);
    chk("len16", 99, lastLen);
    chk("falls16", 16, lastFall);
    chk("txword16", 32'ha5c3, lastTx);
    rdc(`REG_DATA, {4'h0, valB[11:0], 4'h0, valA[11:0]}, "pair12");
    wr(`REG_CTRL, 32'hb);
    res14 <= 1;
    conv(1);
    chk("len14", 87, lastLen);
    chk("txword14", 32'h2970, lastTx[13:0]);
    rdc(`REG_DATA, {18'h0, valA}, "lineA only");
    // Short half period is clamped; 16-bit word around a 14-bit result
    wr(`REG_HALF, 1);
    rdc(`REG_HALF, 1, "half low");
    wr(`REG_CTRL, 32'h9);
    conv(1);
    chk("len clamp", 99, lastLen);
    rdc(`REG_DATA, {18'h0, valA}, "res14 in 16");
    // Disabled: the read waits until enable returns
    wr(`REG_CTRL, 32'he);
    conv(0);
    wr(`REG_CTRL, 32'hf);
    waitFrame(1);
    rdc(`REG_DATA, {2'h0, valB, 2'h0, valA}, "after enable");
    // Fill the FIFO, then one more conversion must wait for space
    wr(`REG_CTRL, 32'hf);
    for (int i = 0; i < DEPTH; i++) conv(1);
    conv(0);
    rdc(`REG_STATUS, 32'h12, "full pend");
    for (int i = 0; i < DEPTH; i++) rdc(`REG_DATA, {2'h0, valB, 2'h0, valA}, "drain");
    waitFrame(1);
    rdc(`REG_DATA, {2'h0, valB, 2'h0, valA}, "late word");
    rdc(`REG_DATA, 0, "empty");
    rdc(`REG_STATUS, 32'h8, "status end");
    giveVerdict();
  end
  // Watchdog, well beyond the expected run of about five thousand cycles
  initial begin
    #400000;
    errTotal++;
    giveVerdict();
  end
endmodule
`default_nettype wire
